// File: pkg/sckl_pkg.sv
// Types shared by the sync check block
package sckl_pkg;
    typedef enum logic [1:0] {SCKL_SA_VA, SCKL_SA_VB, SCKL_SA_VC} sckl_side_a_t;
    typedef enum logic [2:0] {SCKL_SB_VA, SCKL_SB_VB, SCKL_SB_VC,
                              SCKL_SB_VAB, SCKL_SB_VBC, SCKL_SB_VCA} sckl_side_b_t;
    // Element index inside one synchronism element
    typedef enum logic [2:0] {SCKL_E_VDIFF, SCKL_E_PDIFF, SCKL_E_FDIFF, SCKL_E_LIVE_A,
                              SCKL_E_LIVE_B, SCKL_E_DEAD_A, SCKL_E_DEAD_B} sckl_elem_t;
endpackage

// File: pkg/sckl_regs.svh
// Register offsets, field positions, reset values and fixed margins of the sync check block
`ifndef SCKL_REGS_SVH
`define SCKL_REGS_SVH
`define SCKL_OFF_CTRL        8'h00
`define SCKL_OFF_KFACT       8'h04
`define SCKL_OFF_CLOSE_TIME  8'h08
`define SCKL_OFF_VDIFF_SET   8'h0C
`define SCKL_OFF_PDIFF_SET   8'h10
`define SCKL_OFF_FDIFF_SET   8'h14
`define SCKL_OFF_LIVE_A      8'h18
`define SCKL_OFF_LIVE_B      8'h1C
`define SCKL_OFF_DEAD_A      8'h20
`define SCKL_OFF_DEAD_B      8'h24
`define SCKL_OFF_STATUS      8'h28
`define SCKL_CTRL_UNIT_EN    0
`define SCKL_CTRL_INTERNAL   1
`define SCKL_CTRL_FF_BLK_EN  2
`define SCKL_CTRL_CT_COMP    3
`define SCKL_CTRL_VSUP_EN    4
`define SCKL_CTRL_VDIFF_EN   5
`define SCKL_CTRL_PDIFF_EN   6
`define SCKL_CTRL_FDIFF_EN   7
`define SCKL_CTRL_SEQ_ACB    8
`define SCKL_CTRL_SIDEA_LSB  10
`define SCKL_CTRL_SIDEB_LSB  12
`define SCKL_CTRL_MASK_LSB   16
`define SCKL_CTRL_RESET      32'h000A0000
`define SCKL_KFACT_RESET     32'h00000064
`define SCKL_CLOSE_RESET     32'h00000064
`define SCKL_VDIFF_RESET     32'h00000002
`define SCKL_PDIFF_RESET     32'h00000002
`define SCKL_FDIFF_RESET     32'h0000000A
`define SCKL_LIVE_RESET      32'h00000014
`define SCKL_DEAD_RESET      32'h0000000A
`define SCKL_FDIFF_MARGIN_MHZ 10
`define SCKL_PDIFF_MARGIN_DD  20
`define SCKL_FULL_TURN_DD     3600
`define SCKL_HALF_TURN_DD     1800
`define SCKL_RESP_OKAY       2'h0
`define SCKL_RESP_SLVERR     2'h2
`endif

// File: src/sckl_hyst.sv
// Pickup/reset element with hysteresis, updated on each measurement strobe
`timescale 1ns/1ps
module sckl_hyst
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic update,
    input  wire logic pick,
    input  wire logic drop,
    output logic      state
);
    logic state_q;
    logic state_d;

    // State is held between updates; pickup wins only when not picked up
    assign state_d = !update ? state_q : (state_q ? !drop : pick);
    assign state   = state_q;

    // Element state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= 1'b0;
        else
            state_q <= state_d;
    end
endmodule

// File: src/sckl_top.sv
// Synchronism check decision logic with AXI4-Lite settings and status
`timescale 1ns/1ps
`include "sckl_regs.svh"
module sckl_top
#(
    parameter int ELEMENTS = 2
)
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        meas_update,
    input  wire logic [15:0]                 side_a_mag,
    input  wire logic [15:0]                 side_a_ang,
    input  wire logic [15:0]                 side_a_freq,
    input  wire logic [ELEMENTS-1:0][15:0]   side_b_mag,
    input  wire logic [ELEMENTS-1:0][15:0]   side_b_ang,
    input  wire logic [ELEMENTS-1:0][15:0]   side_b_freq,
    input  wire logic                        external_sync_input,
    input  wire logic                        fuse_fail_block,
    input  wire logic                        sync_block_input,
    output logic                             sync_permit_reclose,
    output logic                             sync_permit_manual,
    output logic                             live_line,
    output logic                             dead_line,
    output logic [ELEMENTS-1:0]              live_bus,
    output logic [ELEMENTS-1:0]              dead_bus,
    output logic [ELEMENTS-1:0]              sync_computed
);
    // Settings registers
    logic [31:0] ctrl_q;
    logic [8:0]  kfact_q;
    logic [9:0]  close_time_q;
    logic [4:0]  vdiff_set_q;
    logic [6:0]  pdiff_set_q;
    logic [10:0] fdiff_set_q;
    logic [7:0]  live_a_q;
    logic [7:0]  live_b_q;
    logic [7:0]  dead_a_q;
    logic [7:0]  dead_b_q;

    // AXI handshake state
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // Write path decode
    wire        wr_fire  = aw_held_q && w_held_q && !bvalid_q;
    wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire        wr_known = awaddr_q[1:0] == 2'h0 && awaddr_q <= `SCKL_OFF_DEAD_B;
    wire [31:0] wr_ctrl  = (ctrl_q & ~wmask) | (wdata_q & wmask);
    wire [31:0] wr_val   = wdata_q & wmask;
    wire        ar_fire  = s_axi_arvalid && !rvalid_q;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Address and data are captured independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_q)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && !w_held_q)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `SCKL_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? `SCKL_RESP_OKAY : `SCKL_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // Settings update
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q       <= `SCKL_CTRL_RESET;
            kfact_q      <= 9'(`SCKL_KFACT_RESET);
            close_time_q <= 10'(`SCKL_CLOSE_RESET);
            vdiff_set_q  <= 5'(`SCKL_VDIFF_RESET);
            pdiff_set_q  <= 7'(`SCKL_PDIFF_RESET);
            fdiff_set_q  <= 11'(`SCKL_FDIFF_RESET);
            live_a_q     <= 8'(`SCKL_LIVE_RESET);
            live_b_q     <= 8'(`SCKL_LIVE_RESET);
            dead_a_q     <= 8'(`SCKL_DEAD_RESET);
            dead_b_q     <= 8'(`SCKL_DEAD_RESET);
        end
        else if (wr_fire)
        begin
            unique case (awaddr_q)
                `SCKL_OFF_CTRL:       ctrl_q       <= wr_ctrl & 32'h000F7FFF;
                `SCKL_OFF_KFACT:      kfact_q      <= wr_val[8:0];
                `SCKL_OFF_CLOSE_TIME: close_time_q <= wr_val[9:0];
                `SCKL_OFF_VDIFF_SET:  vdiff_set_q  <= wr_val[4:0];
                `SCKL_OFF_PDIFF_SET:  pdiff_set_q  <= wr_val[6:0];
                `SCKL_OFF_FDIFF_SET:  fdiff_set_q  <= wr_val[10:0];
                `SCKL_OFF_LIVE_A:     live_a_q     <= wr_val[7:0];
                `SCKL_OFF_LIVE_B:     live_b_q     <= wr_val[7:0];
                `SCKL_OFF_DEAD_A:     dead_a_q     <= wr_val[7:0];
                `SCKL_OFF_DEAD_B:     dead_b_q     <= wr_val[7:0];
                default:              ctrl_q       <= ctrl_q;
            endcase
        end
    end

    // Status word: element states of element 0, live and dead line, and both permits
    logic [6:0] elem_state [ELEMENTS];
    wire [31:0] status_w = {14'h0000, sync_permit_manual, sync_permit_reclose,
                            6'h00, live_line, dead_line, 1'b0, elem_state[0]};
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (s_axi_araddr)
            `SCKL_OFF_CTRL:       rd_mux = ctrl_q;
            `SCKL_OFF_KFACT:      rd_mux = {23'h000000, kfact_q};
            `SCKL_OFF_CLOSE_TIME: rd_mux = {22'h000000, close_time_q};
            `SCKL_OFF_VDIFF_SET:  rd_mux = {27'h0000000, vdiff_set_q};
            `SCKL_OFF_PDIFF_SET:  rd_mux = {25'h0000000, pdiff_set_q};
            `SCKL_OFF_FDIFF_SET:  rd_mux = {21'h000000, fdiff_set_q};
            `SCKL_OFF_LIVE_A:     rd_mux = {24'h000000, live_a_q};
            `SCKL_OFF_LIVE_B:     rd_mux = {24'h000000, live_b_q};
            `SCKL_OFF_DEAD_A:     rd_mux = {24'h000000, dead_a_q};
            `SCKL_OFF_DEAD_B:     rd_mux = {24'h000000, dead_b_q};
            `SCKL_OFF_STATUS:     rd_mux = status_w;
            default:              rd_mux = 32'h00000000;
        endcase
    end
    wire rd_known = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `SCKL_OFF_STATUS;

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `SCKL_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_known ? `SCKL_RESP_OKAY : `SCKL_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // Setting fields
    wire [1:0] side_a_sel = ctrl_q[`SCKL_CTRL_SIDEA_LSB +: 2];
    wire [2:0] side_b_sel = ctrl_q[`SCKL_CTRL_SIDEB_LSB +: 3];
    wire [3:0] energ_mask = ctrl_q[`SCKL_CTRL_MASK_LSB +: 4];

    // Reference angle of each selectable voltage for ABC, tenths of a degree
    function automatic int sckl_base_ang(input logic [2:0] sel);
        unique case (sel)
            3'h1:    sckl_base_ang = 1200;
            3'h2:    sckl_base_ang = 2400;
            3'h3:    sckl_base_ang = 3300;
            3'h4:    sckl_base_ang = 900;
            3'h5:    sckl_base_ang = 2100;
            default: sckl_base_ang = 0;
        endcase
    endfunction

    // Side B rotation from the two selections, mirrored for ACB sequence
    wire integer comp_abc = (sckl_base_ang(side_b_sel) - sckl_base_ang({1'b0, side_a_sel})
                        + `SCKL_FULL_TURN_DD) % `SCKL_FULL_TURN_DD;
    wire integer comp_ang = ctrl_q[`SCKL_CTRL_SEQ_ACB] ?
                        (`SCKL_FULL_TURN_DD - comp_abc) % `SCKL_FULL_TURN_DD : comp_abc;

    // Side A detectors, inputs already line-to-neutral normalized
    wire integer va = int'(side_a_mag);
    wire live_a_pick = va > int'(live_a_q) * 10;
    wire live_a_drop = va * 100 < int'(live_a_q) * 950;
    wire dead_a_pick = va < int'(dead_a_q) * 10;
    wire dead_a_drop = va * 100 > int'(dead_a_q) * 950;

    // Positions of the seven element states inside one synchronism element
    localparam int I_VD = int'(sckl_pkg::SCKL_E_VDIFF);
    localparam int I_PD = int'(sckl_pkg::SCKL_E_PDIFF);
    localparam int I_FD = int'(sckl_pkg::SCKL_E_FDIFF);
    localparam int I_LA = int'(sckl_pkg::SCKL_E_LIVE_A);
    localparam int I_LB = int'(sckl_pkg::SCKL_E_LIVE_B);
    localparam int I_DA = int'(sckl_pkg::SCKL_E_DEAD_A);
    localparam int I_DB = int'(sckl_pkg::SCKL_E_DEAD_B);

    wire [ELEMENTS-1:0] permit_w;

    genvar e;
    generate
        for (e = 0; e < ELEMENTS; e++)
        begin : g_elem
            wire integer vb   = int'(side_b_mag[e]);
            wire integer vbs  = vb * int'(kfact_q) / 100;
            wire integer vd   = va > vbs ? va - vbs : vbs - va;
            wire integer df   = int'($signed(side_a_freq)) - int'($signed(side_b_freq[e]));
            wire integer dfa  = df < 0 ? -df : df;
            wire integer corr = ctrl_q[`SCKL_CTRL_CT_COMP] ?
                                int'(close_time_q) * df * 36 / 10000 : 0;
            wire integer raw  = int'(side_a_ang) - int'(side_b_ang[e]) - comp_ang + corr;
            wire integer wrp  = ((raw % `SCKL_FULL_TURN_DD) + `SCKL_FULL_TURN_DD)
                                % `SCKL_FULL_TURN_DD;
            wire integer pd   = wrp > `SCKL_HALF_TURN_DD ? `SCKL_FULL_TURN_DD - wrp : wrp;
            wire integer pset = int'(pdiff_set_q) * 10;
            logic [6:0] pick_v;
            logic [6:0] drop_v;

            // Pickup and reset conditions of the seven elements
            assign pick_v[I_VD] = vd * 100 <= int'(vdiff_set_q) * vbs;
            assign drop_v[I_VD] = vd * 2000 >= int'(vdiff_set_q) * vbs * 21;
            assign pick_v[I_PD] = pd <= pset;
            assign drop_v[I_PD] = pd * 2 > pset * 21 / 10
                                  || pd > pset + `SCKL_PDIFF_MARGIN_DD;
            assign pick_v[I_FD] = dfa < int'(fdiff_set_q);
            assign drop_v[I_FD] = dfa > int'(fdiff_set_q)
                                  + `SCKL_FDIFF_MARGIN_MHZ;
            assign pick_v[I_LA] = live_a_pick;
            assign drop_v[I_LA] = live_a_drop;
            assign pick_v[I_LB] = vb > int'(live_b_q) * 10;
            assign drop_v[I_LB] = vb * 100 < int'(live_b_q) * 950;
            assign pick_v[I_DA] = dead_a_pick;
            assign drop_v[I_DA] = dead_a_drop;
            assign pick_v[I_DB] = vb < int'(dead_b_q) * 10;
            assign drop_v[I_DB] = vb * 100 > int'(dead_b_q) * 950;

            genvar k;
            for (k = 0; k < 7; k++)
            begin : g_hyst
                sckl_hyst u_hyst
                (
                    .aclk    (aclk),
                    .aresetn (aresetn),
                    .update  (meas_update),
                    .pick    (pick_v[k]),
                    .drop    (drop_v[k]),
                    .state   (elem_state[e][k])
                );
            end

            // A side in the band between thresholds shows neither live nor dead
            wire la  = elem_state[e][I_LA] && !elem_state[e][I_DA];
            wire da  = elem_state[e][I_DA] && !elem_state[e][I_LA];
            wire lb  = elem_state[e][I_LB] && !elem_state[e][I_DB];
            wire db  = elem_state[e][I_DB] && !elem_state[e][I_LB];
            wire ll  = la && lb;
            // Mask only selects combinations; detector outputs are kept regardless
            wire en_ok = !ctrl_q[`SCKL_CTRL_VSUP_EN]
                         || (energ_mask[0] && da && db) || (energ_mask[1] && da && lb)
                         || (energ_mask[2] && la && db) || (energ_mask[3] && ll);
            // Difference elements count only with both sides live; disabled ones pass
            wire vd_ok = !ll || !ctrl_q[`SCKL_CTRL_VDIFF_EN] || elem_state[e][I_VD];
            wire pd_ok = !ll || !ctrl_q[`SCKL_CTRL_PDIFF_EN] || elem_state[e][I_PD];
            wire fd_ok = !ll || !ctrl_q[`SCKL_CTRL_FDIFF_EN] || elem_state[e][I_FD];
            wire calc  = ctrl_q[`SCKL_CTRL_UNIT_EN] && !sync_block_input
                         && en_ok && vd_ok && pd_ok && fd_ok;
            wire src   = ctrl_q[`SCKL_CTRL_INTERNAL] ? calc : external_sync_input;
            assign permit_w[e] = src && !(ctrl_q[`SCKL_CTRL_FF_BLK_EN] && fuse_fail_block);

            // Registered outputs of this element
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    live_bus[e]      <= 1'b0;
                    dead_bus[e]      <= 1'b0;
                    sync_computed[e] <= 1'b0;
                end
                else
                begin
                    live_bus[e]      <= lb;
                    dead_bus[e]      <= db;
                    sync_computed[e] <= calc;
                end
            end
        end
    endgenerate

    // Permits to recloser and close command; element 0 feeds reclose, the last element feeds manual
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_permit_reclose <= 1'b0;
            sync_permit_manual  <= 1'b0;
            live_line           <= 1'b0;
            dead_line           <= 1'b0;
        end
        else
        begin
            sync_permit_reclose <= permit_w[0];
            sync_permit_manual  <= permit_w[ELEMENTS-1];
            live_line           <= g_elem[0].la;
            dead_line           <= g_elem[0].da;
        end
    end
endmodule

// File: test/sckl_closer.sv
// Close command model gated by the permit
`timescale 1ns/1ps
module sckl_closer
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic permit,
    input  wire logic close_req,
    output logic      close_cmd
);
    // Close issued only while the permit stands
    always_ff @(posedge aclk)
    begin
        close_cmd <= aresetn && close_req && permit;
    end
endmodule

// File: test/sckl_top_sva.sv
// Port assertions for the sync check block
`timescale 1ns/1ps
module sckl_chk
#(
    parameter int ELEMENTS = 2
)
(
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                meas_update,
    input wire logic                sync_block_input,
    input wire logic                live_line,
    input wire logic                dead_line,
    input wire logic [ELEMENTS-1:0] live_bus,
    input wire logic [ELEMENTS-1:0] dead_bus,
    input wire logic [ELEMENTS-1:0] sync_computed,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [31:0]         s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Two edges without a measurement strobe
    sequence quiet_s;
        !meas_update [*2];
    endsequence
    AST_BLOCK_SYNC: assert property (sync_block_input [*2] |-> sync_computed == '0)
        else $error("sync computed while blocked");
    AST_LINE_EXCL: assert property (!(live_line && dead_line))
        else $error("line live and dead together");
    AST_BUS_EXCL: assert property ((live_bus & dead_bus) == '0)
        else $error("bus live and dead together");
    AST_LINE_HOLD: assert property (quiet_s |=> $stable({live_line, dead_line}))
        else $error("line state moved without update");
    AST_BUS_HOLD: assert property (quiet_s |=> $stable({live_bus, dead_bus}))
        else $error("bus state moved without update");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
    AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule
bind sckl_top sckl_chk #(.ELEMENTS(ELEMENTS)) u_sckl_chk (
    .aclk(aclk), .aresetn(aresetn), .meas_update(meas_update),
    .sync_block_input(sync_block_input), .live_line(live_line), .dead_line(dead_line),
    .live_bus(live_bus), .dead_bus(dead_bus), .sync_computed(sync_computed),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// File: test/tb.sv
// Bench for the sync check block
`timescale 1ns/1ps
`include "sckl_regs.svh"
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, mu = 1'b0, ext = 1'b0, ff = 1'b0, blk = 1'b0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, creq = 1'b0;
    logic awr, wrdy, bv, arr, rv, pr, pm, ll, dl, cr, cm;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [15:0] am = 16'h0;
    logic [1:0][15:0] bm = '0, ba = '0, bf = '0;
    logic [1:0] bresp, rresp, lb, db, sc;
    logic [31:0] cfg [5] = '{32'h1000, 32'h1100, 32'h3000, 32'h5500, 32'h4900};
    logic [15:0] bang [5] = '{16'h0960, 16'h04B0, 16'h012C, 16'h0384, 16'h0834};
    localparam logic [15:0] nv = 16'h08FC, nf = 16'hC350, z = 16'h0;
    int error_cnt = 0, check_count = 0, cyc = 0;
    always #5 aclk = ~aclk;
    sckl_top #(.ELEMENTS(2)) u_sckl_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .meas_update(mu), .side_a_mag(am), .side_a_ang(16'h0),
        .side_a_freq(16'hC350), .side_b_mag(bm), .side_b_ang(ba), .side_b_freq(bf),
        .external_sync_input(ext), .fuse_fail_block(ff), .sync_block_input(blk),
        .sync_permit_reclose(pr), .sync_permit_manual(pm), .live_line(ll),
        .dead_line(dl), .live_bus(lb), .dead_bus(db), .sync_computed(sc));
    sckl_closer u_sckl_closer_r (.aclk(aclk), .aresetn(aresetn), .permit(pr),
        .close_req(creq), .close_cmd(cr));
    sckl_closer u_sckl_closer_m (.aclk(aclk), .aresetn(aresetn), .permit(pm),
        .close_req(creq), .close_cmd(cm));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(da && dw))
        begin
            @(negedge aclk);
            da = da || awr;
            dw = dw || wrdy;
            @(posedge aclk);
            if (da) awv <= 1'b0;
            if (dw) wv <= 1'b0;
        end
        do @(negedge aclk); while (!bv);
        @(posedge aclk);
        br <= 1'b1;
        @(negedge aclk);
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        do @(negedge aclk); while (!arr);
        @(posedge aclk);
        arv <= 1'b0;
        rr <= 1'b1;
        do @(negedge aclk); while (!rv);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
        @(posedge aclk);
        rr <= 1'b0;
    endtask
    // Check permits, closes, detectors and computed sync after n edges
    task automatic ob(input int n, input logic [11:0] e, input logic [11:0] m);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
        chk(32'({cr, cm, pr, pm, ll, dl, lb, db, sc} & m), 32'(e));
        @(posedge aclk);
    endtask
    task automatic mv(input logic [15:0] a, b, g, f, input logic [11:0] e, m);
        am <= a;
        bm <= {b, b};
        ba <= {g, g};
        bf <= {f, f};
        mu <= 1'b1;
        @(posedge aclk);
        mu <= 1'b0;
        ob(2, e, m);
    endtask
    // Cut a hung run short
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        creq <= 1'b1;
        @(posedge aclk);
        rd(`SCKL_OFF_CTRL, `SCKL_CTRL_RESET, `SCKL_RESP_OKAY);
        rd(`SCKL_OFF_KFACT, `SCKL_KFACT_RESET, `SCKL_RESP_OKAY);
        rd(8'h2C, 32'h0, `SCKL_RESP_SLVERR);
        wr(`SCKL_OFF_STATUS, 32'hFFFFFFFF, `SCKL_RESP_SLVERR);
        $display("done registers");
        mv(16'h00C9, nv, z, nf, 12'h0B0, 12'h0FC);
        mv(16'h00BF, nv, z, nf, 12'h0B0, 12'h0FC);
        mv(16'h00BD, nv, z, nf, 12'h030, 12'h0FC);
        mv(16'h0063, 16'h0032, z, nf, 12'h04C, 12'h0FC);
        mv(16'h0096, 16'h0032, z, nf, 12'h00C, 12'h0FC);
        $display("done detectors");
        wr(`SCKL_OFF_CTRL, 32'h3, `SCKL_RESP_OKAY);
        mv(nv, nv, z, nf, 12'hF03, 12'hF03);
        blk <= 1'b1;
        ob(2, 12'h000, 12'h003);
        blk <= 1'b0;
        ff <= 1'b1;
        ob(2, 12'hF03, 12'hF03);
        wr(`SCKL_OFF_CTRL, 32'h7, `SCKL_RESP_OKAY);
        ob(2, 12'h003, 12'hF03);
        ext <= 1'b1;
        wr(`SCKL_OFF_CTRL, 32'h5, `SCKL_RESP_OKAY);
        ob(2, 12'h000, 12'hF00);
        ff <= 1'b0;
        ob(2, 12'hF00, 12'hF00);
        ext <= 1'b0;
        ob(2, 12'h000, 12'hF00);
        wr(`SCKL_OFF_CTRL, 32'h00080013, `SCKL_RESP_OKAY);
        mv(nv, 16'h0032, z, nf, 12'h00C, 12'h00F);
        wr(`SCKL_OFF_CTRL, 32'h00040013, `SCKL_RESP_OKAY);
        mv(nv, 16'h0032, z, nf, 12'h00F, 12'h00F);
        $display("done permits");
        wr(`SCKL_OFF_CTRL, 32'h00080033, `SCKL_RESP_OKAY);
        mv(nv, nv, z, nf, 12'h003, 12'h003);
        mv(nv, 16'h08CD, z, nf, 12'h003, 12'h003);
        mv(nv, 16'h08C0, z, nf, 12'h000, 12'h003);
        mv(nv, 16'h08CD, z, nf, 12'h000, 12'h003);
        wr(`SCKL_OFF_KFACT, 32'h000000C8, `SCKL_RESP_OKAY);
        mv(nv, 16'h047E, z, nf, 12'h003, 12'h003);
        bm <= {16'h08C0, 16'h047E};
        mu <= 1'b1;
        @(posedge aclk);
        mu <= 1'b0;
        ob(2, 12'hA01, 12'hF03);
        wr(`SCKL_OFF_KFACT, 32'h00000064, `SCKL_RESP_OKAY);
        $display("done voltage");
        wr(`SCKL_OFF_CTRL, 32'h00080053, `SCKL_RESP_OKAY);
        mv(nv, nv, 16'h0015, nf, 12'h003, 12'h003);
        mv(nv, nv, 16'h0016, nf, 12'h000, 12'h003);
        mv(nv, nv, 16'h0015, nf, 12'h000, 12'h003);
        for (int i = 0; i < 5; i++)
        begin
            wr(`SCKL_OFF_CTRL, 32'h00080053 | cfg[i], `SCKL_RESP_OKAY);
            mv(nv, nv, bang[i], nf, 12'h003, 12'h003);
        end
        rd(`SCKL_OFF_CTRL, 32'h00084953, `SCKL_RESP_OKAY);
        wr(`SCKL_OFF_CTRL, 32'h0008005B, `SCKL_RESP_OKAY);
        mv(nv, nv, 16'h012C, 16'hC31E, 12'h000, 12'h003);
        mv(nv, nv, 16'h001E, 16'hC31E, 12'h003, 12'h003);
        mv(nv, nv, 16'h001E, 16'hC382, 12'h000, 12'h003);
        $display("done phase");
        wr(`SCKL_OFF_CTRL, 32'h00080093, `SCKL_RESP_OKAY);
        mv(nv, nv, z, 16'hC34B, 12'h003, 12'h003);
        mv(nv, nv, z, 16'hC35F, 12'h003, 12'h003);
        mv(nv, nv, z, 16'hC369, 12'h000, 12'h003);
        mv(nv, nv, z, 16'hC35F, 12'h000, 12'h003);
        rd(`SCKL_OFF_STATUS, 32'h0000021B, `SCKL_RESP_OKAY);
        $display("done frequency");
        give_verdict();
    end
endmodule
